//--- logic/rts_pkg.sv
`default_nettype none
package rts_pkg;
  // Clock and control tick
  localparam int CLK_MHZ       = 200;
  localparam int TICK_US       = 100;
  localparam int TICK_CYC      = TICK_US * CLK_MHZ;
  // Ramp and S-curve times use a 0.01 s step, dwell times a 0.1 s step
  localparam int TIME_LSB_US   = 10000;
  localparam int DWELL_LSB_US  = 100000;
  localparam int TICKS_PER_LSB = TIME_LSB_US / TICK_US;
  localparam int DWELL_TPL     = DWELL_LSB_US / TICK_US;
  localparam logic [6:0] WFULL = 7'(TICKS_PER_LSB);
  localparam logic [31:0] THR_SCALE = 32'(TICKS_PER_LSB * TICKS_PER_LSB);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_DIN   = 8'h04;
  localparam logic [7:0] OFF_TIME  = 8'h08;
  localparam logic [7:0] OFF_TLAST = 8'h24;
  localparam logic [7:0] OFF_SWF   = 8'h28;
  localparam logic [7:0] OFF_AIN   = 8'h2c;
  localparam logic [7:0] OFF_SC    = 8'h30;
  localparam logic [7:0] OFF_SLAST = 8'h3c;
  localparam logic [7:0] OFF_DW    = 8'h40;
  localparam logic [7:0] OFF_DLAST = 8'h4c;
  localparam logic [7:0] OFF_STALL = 8'h50;
  localparam logic [7:0] OFF_FREQ  = 8'h54;
  localparam logic [7:0] OFF_REF   = 8'h58;
  localparam logic [7:0] OFF_VIN   = 8'h5c;
  localparam logic [7:0] OFF_STAT  = 8'h60;

  // Control register field positions
  localparam int CT_RUN = 0;
  localparam int CT_C400 = 1;
  localparam int CT_CLOOP = 2;
  localparam int CT_DUTY = 4;
  localparam int CT_AMODE = 8;
  localparam int CT_DMODE = 12;

  // Function codes
  localparam logic [7:0] FN_SEL1  = 8'h07;
  localparam logic [7:0] FN_SEL2  = 8'h1a;
  localparam logic [7:0] FN_TGAIN = 8'h05;
  localparam int AIN_SHIFT = 10;

  // Stall figures, percent of rated current and volts
  localparam logic [6:0] PCT_FULL  = 7'h64;
  localparam logic [6:0] PCT_NEAR  = 7'h55;
  localparam logic [7:0] LVL_ND    = 8'h96;
  localparam logic [7:0] LVL_HD    = 8'h78;
  localparam logic [7:0] CP_DEF    = 8'h32;
  localparam logic [9:0] V_200     = 10'h17c;
  localparam logic [9:0] V_400H    = 10'h2f8;
  localparam logic [9:0] V_400L    = 10'h294;
  localparam logic [15:0] VIN_SPLIT = 16'h0190;
  localparam logic [9:0] V_MARGIN  = 10'h014;

  // Reset values
  localparam logic [15:0] TIME_DEF = 16'h03e8;
  localparam logic [15:0] SC_DEF   = 16'h0014;
  localparam logic [15:0] MAXF_DEF = 16'h0258;
  localparam logic [15:0] VIN_DEF  = 16'h0190;
  localparam logic [1:0]  AMODE_DEF = 2'h1;
  localparam logic [1:0]  DMODE_DEF = 2'h1;

  typedef enum logic [2:0] {ST_IDLE, ST_UPDWELL, ST_RUN, ST_DNDWELL, ST_STOP} rts_state_t;
endpackage
`default_nettype wire

//--- logic/rts_ramp.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rts_ramp #(
  parameter int ADDR_W      = 8,
  parameter int NTERM       = 4,
  parameter int TICK_CYCLES = rts_pkg::TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [NTERM-1:0]  dinTerm,
  input  wire logic [9:0]        secondAnalogInput,
  input  wire logic [9:0]        outCurrentPct,
  input  wire logic [9:0]        busVoltage,
  output logic [15:0]            freqCmd,
  output logic                   running,
  output logic                   accelStallActive,
  output logic                   decelHold
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic              runCmd_r;
  logic              class400_r;
  logic              closedLoop_r;
  logic [1:0]        dutyRatingSelect_r;
  logic [1:0]        accelStallMode_r;
  logic [1:0]        decelStallMode_r;
  logic [7:0]        dinFunc_r [NTERM];
  logic [15:0]       rampTime_r [8];
  logic [15:0]       rampSwitchFreq_r;
  logic [7:0]        secondAnalogFunc_r;
  logic [15:0]       scurve_r [4];
  logic [15:0]       dwell_r [4];
  logic [7:0]        accelStallLevel_r;
  logic [7:0]        cpStallLimit_r;
  logic [15:0]       maxFreq_r;
  logic [15:0]       baseFreq_r;
  logic [15:0]       freqRef_r;
  logic [15:0]       inputVoltage_r;

  logic              wrPend_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [31:0]       rdVal;
  logic              addrPhase;

  logic [NTERM-1:0]  dinS1_r;
  logic [NTERM-1:0]  dinS2_r;
  logic [9:0]        ainS1_r;
  logic [9:0]        ainS2_r;

  rts_pkg::rts_state_t state_r;
  logic [15:0]       freq_r;
  logic [1:0]        pair;
  logic [31:0]       tickCnt_r;
  logic              tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  assign addrPhase = hsel && hready && htrans[1];

  // Address phase capture; word size assumed, hsize not checked
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr;
      end
    end
  end

  // Read data is registered so it stands for the whole data phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite) begin
        hrdata <= rdVal;
      end
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    logic [7:0] a;
    logic [7:0] d;
    a = 8'(haddr);
    d = 8'h00;
    rdVal = 32'h00000000;
    if (a == rts_pkg::OFF_CTRL) begin
      rdVal[rts_pkg::CT_RUN]   = runCmd_r;
      rdVal[rts_pkg::CT_C400]  = class400_r;
      rdVal[rts_pkg::CT_CLOOP] = closedLoop_r;
      rdVal[rts_pkg::CT_DUTY+:2]  = dutyRatingSelect_r;
      rdVal[rts_pkg::CT_AMODE+:2] = accelStallMode_r;
      rdVal[rts_pkg::CT_DMODE+:2] = decelStallMode_r;
    end else if (a == rts_pkg::OFF_DIN) begin
      for (int i = 0; i < NTERM; i++) begin
        rdVal[8*i+:8] = dinFunc_r[i];
      end
    end else if (a >= rts_pkg::OFF_TIME && a <= rts_pkg::OFF_TLAST) begin
      d = a - rts_pkg::OFF_TIME;
      rdVal[15:0] = rampTime_r[d[4:2]];
    end else if (a == rts_pkg::OFF_SWF) begin
      rdVal[15:0] = rampSwitchFreq_r;
    end else if (a == rts_pkg::OFF_AIN) begin
      rdVal[7:0] = secondAnalogFunc_r;
    end else if (a >= rts_pkg::OFF_SC && a <= rts_pkg::OFF_SLAST) begin
      d = a - rts_pkg::OFF_SC;
      rdVal[15:0] = scurve_r[d[3:2]];
    end else if (a >= rts_pkg::OFF_DW && a <= rts_pkg::OFF_DLAST) begin
      d = a - rts_pkg::OFF_DW;
      rdVal[15:0] = dwell_r[d[3:2]];
    end else if (a == rts_pkg::OFF_STALL) begin
      rdVal[15:0] = {cpStallLimit_r, accelStallLevel_r};
    end else if (a == rts_pkg::OFF_FREQ) begin
      rdVal = {baseFreq_r, maxFreq_r};
    end else if (a == rts_pkg::OFF_REF) begin
      rdVal[15:0] = freqRef_r;
    end else if (a == rts_pkg::OFF_VIN) begin
      rdVal[15:0] = inputVoltage_r;
    end else if (a == rts_pkg::OFF_STAT) begin
      rdVal = {6'h00, decelHold, accelStallActive, 2'h0, pair,
               1'b0, 3'(state_r), freq_r};
    end
  end

  // Write offset as a byte address, decoded in the data phase
  logic [7:0] wrA;
  assign wrA = 8'(wrAddr_r);

  // Write decode; a duty change reloads the stall level default
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      runCmd_r           <= 1'b0;
      class400_r         <= 1'b0;
      closedLoop_r       <= 1'b0;
      dutyRatingSelect_r <= 2'h0;
      accelStallMode_r   <= rts_pkg::AMODE_DEF;
      decelStallMode_r   <= rts_pkg::DMODE_DEF;
      for (int i = 0; i < NTERM; i++) begin
        dinFunc_r[i] <= 8'h00;
      end
      for (int i = 0; i < 8; i++) begin
        rampTime_r[i] <= rts_pkg::TIME_DEF;
      end
      for (int i = 0; i < 4; i++) begin
        scurve_r[i] <= (i == 3) ? 16'h0000 : rts_pkg::SC_DEF;
        dwell_r[i]  <= 16'h0000;
      end
      rampSwitchFreq_r   <= 16'h0000;
      secondAnalogFunc_r <= 8'h00;
      accelStallLevel_r  <= rts_pkg::LVL_ND;
      cpStallLimit_r     <= rts_pkg::CP_DEF;
      maxFreq_r          <= rts_pkg::MAXF_DEF;
      baseFreq_r         <= rts_pkg::MAXF_DEF;
      freqRef_r          <= 16'h0000;
      inputVoltage_r     <= rts_pkg::VIN_DEF;
    end else if (wrPend_r) begin
      if (wrA == rts_pkg::OFF_CTRL) begin
        runCmd_r           <= hwdata[rts_pkg::CT_RUN];
        class400_r         <= hwdata[rts_pkg::CT_C400];
        closedLoop_r       <= hwdata[rts_pkg::CT_CLOOP];
        dutyRatingSelect_r <= hwdata[rts_pkg::CT_DUTY+:2];
        accelStallMode_r   <= hwdata[rts_pkg::CT_AMODE+:2];
        decelStallMode_r   <= hwdata[rts_pkg::CT_DMODE+:2];
        if (hwdata[rts_pkg::CT_DUTY+:2] != dutyRatingSelect_r) begin
          accelStallLevel_r <= (hwdata[rts_pkg::CT_DUTY+:2] == 2'h0 ||
                                hwdata[rts_pkg::CT_DUTY+:2] == 2'h3) ?
                               rts_pkg::LVL_ND : rts_pkg::LVL_HD;
        end
      end else if (wrA == rts_pkg::OFF_DIN) begin
        for (int i = 0; i < NTERM; i++) begin
          dinFunc_r[i] <= hwdata[8*i+:8];
        end
      end else if (wrA >= rts_pkg::OFF_TIME && wrA <= rts_pkg::OFF_TLAST) begin
        rampTime_r[3'((wrA - rts_pkg::OFF_TIME) >> 2)] <= hwdata[15:0];
      end else if (wrA == rts_pkg::OFF_SWF) begin
        rampSwitchFreq_r <= hwdata[15:0];
      end else if (wrA == rts_pkg::OFF_AIN) begin
        secondAnalogFunc_r <= hwdata[7:0];
      end else if (wrA >= rts_pkg::OFF_SC && wrA <= rts_pkg::OFF_SLAST) begin
        scurve_r[2'((wrA - rts_pkg::OFF_SC) >> 2)] <= hwdata[15:0];
      end else if (wrA >= rts_pkg::OFF_DW && wrA <= rts_pkg::OFF_DLAST) begin
        dwell_r[2'((wrA - rts_pkg::OFF_DW) >> 2)] <= hwdata[15:0];
      end else if (wrA == rts_pkg::OFF_STALL) begin
        accelStallLevel_r <= hwdata[7:0];
        cpStallLimit_r    <= hwdata[15:8];
      end else if (wrA == rts_pkg::OFF_FREQ) begin
        maxFreq_r  <= hwdata[15:0];
        baseFreq_r <= hwdata[31:16];
      end else if (wrA == rts_pkg::OFF_REF) begin
        freqRef_r <= hwdata[15:0];
      end else if (wrA == rts_pkg::OFF_VIN) begin
        inputVoltage_r <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the analog word changes slowly, skew is harmless
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dinS1_r <= '0;
      dinS2_r <= '0;
      ainS1_r <= 10'h000;
      ainS2_r <= 10'h000;
    end else begin
      dinS1_r <= dinTerm;
      dinS2_r <= dinS1_r;
      ainS1_r <= secondAnalogInput;
      ainS2_r <= ainS1_r;
    end
  end

  // Control tick divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_r <= 32'h00000000;
      tick_r    <= 1'b0;
    end else if (tickCnt_r >= 32'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 32'h00000000;
      tick_r    <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h00000001;
      tick_r    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp pair selection, re-evaluated every cycle
  logic        sel1;
  logic        sel2;
  logic [15:0] accSet;
  logic [15:0] decSet;
  logic [25:0] gainProd;

  always_comb begin
    sel1 = 1'b0;
    sel2 = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      sel1 = sel1 | (dinS2_r[i] && dinFunc_r[i] == rts_pkg::FN_SEL1);
      sel2 = sel2 | (dinS2_r[i] && dinFunc_r[i] == rts_pkg::FN_SEL2);
    end
    if (rampSwitchFreq_r != 16'h0000) begin
      pair = (freq_r < rampSwitchFreq_r) ? 2'h3 : 2'h0;
    end else begin
      pair = {sel2, sel1};
    end
    gainProd = 26'(rampTime_r[0]) * 26'(ainS2_r);
    accSet   = rampTime_r[{pair, 1'b0}];
    decSet   = rampTime_r[{pair, 1'b1}];
    if (secondAnalogFunc_r == rts_pkg::FN_TGAIN && pair == 2'h0) begin
      accSet = gainProd[rts_pkg::AIN_SHIFT+:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall detection
  // Current above an effective level; in the constant-power range the
  // level is scaled by base/f without a divider, and floored at the limit
  function automatic logic overCur(input logic [9:0] cur, input logic [15:0] f,
                                   input logic [7:0] lvl, input logic [7:0] cp,
                                   input logic [15:0] base, input logic [6:0] pct);
    logic [39:0] lhs;
    logic [39:0] rhs;
    logic        floorOk;
    lhs = 40'(cur) * 40'(rts_pkg::PCT_FULL);
    rhs = 40'(lvl) * 40'(pct);
    floorOk = lhs >= 40'(cp) * 40'(pct);
    if (f > base) begin
      lhs = 40'(cur) * 40'(f) * 40'(rts_pkg::PCT_FULL);
      rhs = 40'(lvl) * 40'(base) * 40'(pct);
      return (lhs >= rhs) && floorOk;
    end
    return lhs >= rhs;
  endfunction

  logic       curOver;
  logic       curNear;
  logic [9:0] busLevel;
  logic       busHigh;
  logic       busLow;
  logic [1:0] decMode;

  always_comb begin
    curOver = overCur(outCurrentPct, freq_r, accelStallLevel_r, cpStallLimit_r,
                      baseFreq_r, rts_pkg::PCT_FULL);
    curNear = overCur(outCurrentPct, freq_r, accelStallLevel_r, cpStallLimit_r,
                      baseFreq_r, rts_pkg::PCT_NEAR);
    if (!class400_r) begin
      busLevel = rts_pkg::V_200;
    end else if (inputVoltage_r >= rts_pkg::VIN_SPLIT) begin
      busLevel = rts_pkg::V_400H;
    end else begin
      busLevel = rts_pkg::V_400L;
    end
    busHigh = busVoltage >= busLevel;
    // Widened so a full-scale bus reading cannot wrap round to low
    busLow  = 11'(busVoltage) + 11'(rts_pkg::V_MARGIN) < 11'(busLevel);
    // Braking mode is unusable in closed loop, fall back to plain decel
    decMode = (closedLoop_r && decelStallMode_r == 2'h3) ? 2'h0 : decelStallMode_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer target
  logic [15:0] target;
  logic [25:0] dwellCnt_r;
  logic        atTarget;

  always_comb begin
    case (state_r)
      rts_pkg::ST_UPDWELL: target = dwell_r[0];
      rts_pkg::ST_RUN:     target = freqRef_r;
      rts_pkg::ST_DNDWELL: target = dwell_r[2];
      default:             target = 16'h0000;
    endcase
    atTarget = freq_r == target;
  end

  // Run/stop sequence with dwell holds; stop is always a ramp to zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= rts_pkg::ST_IDLE;
      dwellCnt_r <= 26'h0000000;
    end else if (tick_r) begin
      case (state_r)
        rts_pkg::ST_IDLE: begin
          dwellCnt_r <= 26'h0000000;
          if (runCmd_r) begin
            state_r <= rts_pkg::ST_UPDWELL;
          end
        end
        rts_pkg::ST_UPDWELL: begin
          if (!runCmd_r) begin
            state_r    <= rts_pkg::ST_DNDWELL;
            dwellCnt_r <= 26'h0000000;
          end else if (atTarget) begin
            if (dwellCnt_r >= 26'(dwell_r[1]) * 26'(rts_pkg::DWELL_TPL)) begin
              state_r <= rts_pkg::ST_RUN;
            end else begin
              dwellCnt_r <= dwellCnt_r + 26'h0000001;
            end
          end
        end
        rts_pkg::ST_RUN: begin
          dwellCnt_r <= 26'h0000000;
          if (!runCmd_r) begin
            state_r <= rts_pkg::ST_DNDWELL;
          end
        end
        rts_pkg::ST_DNDWELL: begin
          if (runCmd_r) begin
            state_r <= rts_pkg::ST_RUN;
          end else if (atTarget) begin
            if (dwellCnt_r >= 26'(dwell_r[3]) * 26'(rts_pkg::DWELL_TPL)) begin
              state_r <= rts_pkg::ST_STOP;
            end else begin
              dwellCnt_r <= dwellCnt_r + 26'h0000001;
            end
          end
        end
        rts_pkg::ST_STOP: begin
          if (freq_r == 16'h0000) begin
            state_r <= rts_pkg::ST_IDLE;
          end
        end
        default: state_r <= rts_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp engine
  logic        goUp;
  logic        goDn;
  logic [15:0] rampT;
  logic [15:0] sStart;
  logic [15:0] sEnd;
  logic        endZone;
  logic [22:0] incr;
  logic        fast;
  logic        hold;
  logic [31:0] thr;
  logic [31:0] accNxt;
  logic [31:0] acc_r;
  logic [6:0]  weight_r;
  logic [15:0] subCnt_r;
  logic [1:0]  dir_r;

  always_comb begin
    goUp   = freq_r < target;
    goDn   = freq_r > target;
    rampT  = goUp ? accSet : decSet;
    rampT  = (rampT == 16'h0000) ? 16'h0001 : rampT;
    sStart = goUp ? scurve_r[0] : scurve_r[2];
    sEnd   = goUp ? scurve_r[1] : scurve_r[3];
    // Begin rounding off once the rest fits in half an end corner
    endZone = 34'(goUp ? target - freq_r : freq_r - target) * 34'(rampT) * 34'h2
              <= 34'(maxFreq_r) * 34'(sEnd);
    incr  = 23'(maxFreq_r) * 23'(weight_r);
    thr   = 32'(rampT) * rts_pkg::THR_SCALE;
    fast  = 1'b0;
    hold  = 1'b0;
    if (goUp) begin
      if (accelStallMode_r == 2'h1) begin
        hold = curOver;
        incr = curNear ? incr >> 1 : incr;
      end else if (accelStallMode_r == 2'h2) begin
        hold = curOver;
        fast = !curOver;
      end
    end else if (goDn) begin
      case (decMode)
        2'h1: hold = busHigh;
        2'h2: incr = busLow ? 23'(incr << 1) : incr;
        2'h3: fast = !busHigh;
        default: hold = 1'b0;
      endcase
    end
    accNxt = acc_r + 32'(incr);
  end

  // S-curve weight: rises over the start corner, falls over the end one,
  // so the total time becomes set time plus half the corner sum
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      weight_r <= 7'h00;
      subCnt_r <= 16'h0000;
      dir_r    <= 2'h0;
    end else if (tick_r) begin
      dir_r <= {goDn, goUp};
      if ({goDn, goUp} != dir_r || !(goUp || goDn)) begin
        weight_r <= 7'h00;
        subCnt_r <= 16'h0000;
      end else if (endZone && sEnd != 16'h0000) begin
        if (subCnt_r + 16'h0001 >= sEnd) begin
          subCnt_r <= 16'h0000;
          weight_r <= (weight_r > 7'h01) ? weight_r - 7'h01 : 7'h01;
        end else begin
          subCnt_r <= subCnt_r + 16'h0001;
        end
      end else if (weight_r < rts_pkg::WFULL) begin
        if (sStart == 16'h0000) begin
          weight_r <= rts_pkg::WFULL;
        end else if (subCnt_r + 16'h0001 >= sStart) begin
          subCnt_r <= 16'h0000;
          weight_r <= weight_r + 7'h01;
        end else begin
          subCnt_r <= subCnt_r + 16'h0001;
        end
      end
    end
  end

  // Frequency accumulator; one count per tick at most keeps it monotonic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r  <= 32'h00000000;
      freq_r <= 16'h0000;
    end else if (tick_r) begin
      if (!(goUp || goDn) || hold) begin
        acc_r <= hold ? acc_r : 32'h00000000;
      end else if (fast || accNxt >= thr) begin
        acc_r  <= (fast || accNxt - thr >= thr) ? 32'h00000000 : accNxt - thr;
        freq_r <= goUp ? freq_r + 16'h0001 : freq_r - 16'h0001;
      end else begin
        acc_r <= accNxt;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      freqCmd          <= 16'h0000;
      running          <= 1'b0;
      accelStallActive <= 1'b0;
      decelHold        <= 1'b0;
    end else begin
      freqCmd          <= freq_r;
      running          <= state_r != rts_pkg::ST_IDLE;
      accelStallActive <= goUp && (accelStallMode_r != 2'h0) && curNear;
      decelHold        <= goDn && hold;
    end
  end

endmodule
`default_nettype wire

//--- test/rts_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module rts_motor_model (
  input  wire logic       mclk,
  input  wire logic [9:0] loadPct,
  input  wire logic [9:0] busSet,
  output logic      [9:0] outCurrentPct,
  output logic      [9:0] busVoltage
);
  // Sensors lag one cycle, as a sampled power stage would
  always_ff @(posedge mclk) begin
    outCurrentPct <= loadPct;
    busVoltage    <= busSet;
  end
endmodule
`default_nettype wire

//--- test/rts_ramp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rts_ramp_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] freqCmd,
  input wire logic        running,
  input wire logic        accelStallActive,
  input wire logic        decelHold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Three held cycles absorb the one-cycle lag of the command
  sequence heldDecel; decelHold [*3]; endsequence
  a_no_wait: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_unit_step: assert property (freqCmd - $past(freqCmd) <= 16'h0001 ||
    $past(freqCmd) - freqCmd <= 16'h0001) else $error("step too large");
  a_idle_zero: assert property (!running && !$past(running) |-> freqCmd == 16'h0000)
    else $error("freq while idle");
  a_stall_run: assert property (accelStallActive |-> running) else $error("stall idle");
  a_hold_run: assert property (decelHold |-> running) else $error("hold idle");
  a_hold_freq: assert property (heldDecel |-> $stable(freqCmd)) else $error("hold moved");
  a_flags_apart: assert property (!(accelStallActive && decelHold)) else $error("both");
endmodule
bind rts_ramp rts_ramp_properties chk (.mclk, .rst_b, .hreadyout, .hresp, .freqCmd, .running,
  .accelStallActive, .decelHold);
`default_nettype wire

//--- test/rts_ramp_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin errorCnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module rts_ramp_tb;
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic [7:0]       haddr = 8'h00;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [31:0]      rd;
  logic [3:0]       dinTerm = 4'h0;
  logic [9:0]       loadPct = 10'h032;
  logic [9:0]       busSet = 10'h12c;
  wire logic        hreadyout, hresp, running, stall, hold;
  wire logic [31:0] hrdata;
  wire logic [9:0]  cur, bus;
  wire logic [15:0] freqCmd;
  int               errorCnt = 0;
  int               cmpCount = 0;
  // Short tick keeps ramps to a few hundred cycles
  always #2.5 mclk = ~mclk;
  rts_ramp #(.TICK_CYCLES(20)) uut (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dinTerm,
    .secondAnalogInput(10'h000), .outCurrentPct(cur), .busVoltage(bus), .freqCmd, .running,
    .accelStallActive(stall), .decelHold(hold));
  rts_motor_model motor (.mclk, .loadPct, .busSet, .outCurrentPct(cur), .busVoltage(bus));
  //////////////////////////////////////////////////////////////////////////////////
  // Single transfer; no cycle count assumed, the watchdog ends a hang
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped read, duty reload of the level
  task automatic tDefaults;
    ahb(0, 8'h00, 0); `CHK("ctrl", 32'h00001100, rd)
    ahb(0, 8'h50, 0); `CHK("lvl", 32'h00003296, rd)
    ahb(0, 8'hfc, 0); `CHK("unmapped", 32'h0, rd)
    ahb(1, 8'h00, 32'h1110);
    ahb(0, 8'h50, 0); `CHK("duty lvl", 32'h00003278, rd)
    ahb(1, 8'h00, 32'h1100);
    $display("test defaults done");
  endtask
  // Every combination of the two select terminals decodes to its pair
  task automatic tPairs;
    ahb(1, 8'h04, 32'h00001a07);
    for (int i = 0; i < 4; i++) begin
      dinTerm <= 4'(i);
      repeat (4) @(posedge mclk);
      ahb(0, 8'h60, 0); `CHK("pair", 2'(i), rd[21:20])
    end
    $display("test pairs done");
  endtask
  // Stop with the bus above level: only mode 1 may hold
  task automatic tStop(input logic [3:0] m);
    ahb(1, 8'h00, 32'({m, 12'h101}));
    repeat (700) @(posedge mclk);
    `CHK("top", 16'd20, freqCmd)
    busSet <= 10'h190;
    ahb(1, 8'h00, 32'({m, 12'h100}));
    repeat (700) @(posedge mclk);
    `CHK("hold", m == 1, hold)
    `CHK("freq", (m == 1) ? 16'd20 : 16'd0, freqCmd)
    busSet <= 10'h12c;
    repeat (700) @(posedge mclk);
    `CHK("stopped", 1'b0, running)
    $display("test stop mode %0d done", m);
  endtask
  // Current above level holds the ramp; the level switch overrides pair 1
  task automatic tStall;
    dinTerm <= 4'h1;
    loadPct <= 10'h0a0;
    ahb(1, 8'h00, 32'h1101);
    repeat (200) @(posedge mclk);
    `CHK("stall", 1'b1, stall)
    `CHK("stall freq", 16'd0, freqCmd)
    ahb(0, 8'h60, 0); `CHK("low pair", 2'h3, rd[21:20])
    loadPct <= 10'h032;
    repeat (700) @(posedge mclk);
    `CHK("stall free", 1'b0, stall)
    `CHK("stall top", 16'd20, freqCmd)
    ahb(0, 8'h60, 0); `CHK("high pair", 2'h0, rd[21:20])
    ahb(1, 8'h00, 32'h1100);
    repeat (700) @(posedge mclk);
    `CHK("stall stop", 1'b0, running)
    $display("test stall done");
  endtask
  //////////////////////////////////////////////////////////////////////////////////
  // Main sequence; times 0.01 s so ramps saturate at one count per tick
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    tDefaults;
    tPairs;
    for (int a = 8; a <= 60; a += 4) ahb(1, 8'(a), 32'(a < 44));
    ahb(1, 8'h58, 32'd20);
    for (int m = 0; m < 4; m++) tStop(4'(m));
    tStall;
    tallyAndFinish;
  end
  // Watchdog well beyond the expected ten thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errorCnt++;
    tallyAndFinish;
  end
endmodule
`default_nettype wire
